/* File: core/mctr_pkg.sv */
package mctr_pkg;
    // register byte addresses on the apb bus
    localparam logic [11:0] MCTR_ADDR_CTRL = 12'h000;
    localparam logic [11:0] MCTR_ADDR_CNTL = 12'h004;
    localparam logic [11:0] MCTR_ADDR_CNTH = 12'h008;
    localparam logic [11:0] MCTR_ADDR_IRQ = 12'h00C;
    // control register field positions
    localparam int MCTR_CTRL_WIDE = 7;
    localparam int MCTR_CTRL_ROUTE_HI = 6;
    localparam int MCTR_CTRL_PS_HI = 5;
    localparam int MCTR_CTRL_PS_LO = 4;
    localparam int MCTR_CTRL_ROUTE_LO = 3;
    localparam int MCTR_CTRL_NOSYNC = 2;
    localparam int MCTR_CTRL_SRC = 1;
    localparam int MCTR_CTRL_RUN = 0;
    // irq register field positions
    localparam int MCTR_IRQ_FLAG = 1;
    localparam int MCTR_IRQ_EN = 9;
    // reset values
    localparam logic [7:0] MCTR_CTRL_RST = 8'h00;
    localparam logic [15:0] MCTR_COUNT_RST = 16'h0000;
    // compare mode that fires the special event trigger
    localparam logic [3:0] MCTR_MODE_SPECIAL = 4'hB;
    // instruction cycle is four system clocks
    localparam logic [1:0] MCTR_INSTR_DIV = 2'h3;
    // edge detector states for the external input
    typedef enum logic [1:0] {
        MCTR_EDGE_ARM = 2'b00,
        MCTR_EDGE_LOW = 2'b01,
        MCTR_EDGE_HIGH = 2'b10
    } mctr_edge_t;
endpackage

/* File: core/mctr_edge.sv */
`timescale 1ns/1ps
// turns a sampled external clock into one-cycle rising edge pulses
module mctr_edge (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_level,
    input wire logic i_clear,
    output logic o_rise
);
    import mctr_pkg::*;

    mctr_edge_t state_reg; // waits for a first low before counting

    // a rise only counts after a low has been seen first
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= MCTR_EDGE_ARM;
        end else if (i_clear) begin
            state_reg <= MCTR_EDGE_ARM;
        end else begin
            case (state_reg)
                MCTR_EDGE_ARM: begin
                    if (!i_level) begin
                        state_reg <= MCTR_EDGE_LOW;
                    end
                end
                MCTR_EDGE_LOW: begin
                    if (i_level) begin
                        state_reg <= MCTR_EDGE_HIGH;
                    end
                end
                MCTR_EDGE_HIGH: begin
                    if (!i_level) begin
                        state_reg <= MCTR_EDGE_LOW;
                    end
                end
                default: begin
                    state_reg <= MCTR_EDGE_ARM;
                end
            endcase
        end
    end

    // combinational pulse in the cycle the high level is first seen
    assign o_rise = (state_reg == MCTR_EDGE_LOW) && i_level && !i_clear;
endmodule

/* File: core/mctr_prescale.sv */
`timescale 1ns/1ps
// divides count ticks by 1, 2, 4 or 8
module mctr_prescale (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_tick,
    input wire logic i_clear,
    input wire logic [1:0] i_sel,
    output logic o_tick
);
    import mctr_pkg::*;

    logic [2:0] div_reg; // running prescale count
    logic [2:0] mask; // terminal pattern for the chosen ratio

    // 00 -> 1, 01 -> 2, 10 -> 4, 11 -> 8
    always_comb begin
        case (i_sel)
            2'b00: mask = 3'h0;
            2'b01: mask = 3'h1;
            2'b10: mask = 3'h3;
            default: mask = 3'h7;
        endcase
    end

    // clear takes priority so a low byte write restarts the ratio
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            div_reg <= 3'h0;
        end else if (i_clear) begin
            div_reg <= 3'h0;
        end else if (i_tick) begin
            div_reg <= ((div_reg & mask) == mask) ? 3'h0 : div_reg + 3'h1;
        end
    end

    assign o_tick = i_tick && !i_clear && ((div_reg & mask) == mask);

    // a low byte write restarts the ratio from zero
    a_clear_restarts: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_clear |=> (div_reg == 3'h0))
        else $error("prescaler not cleared by low write");
endmodule

/* File: core/mctr_top.sv */
`timescale 1ns/1ps
// Operation
// - wide bit makes 16-bit access atomic
// - route select feeds each capture channel
// - two-bit prescale divides by 1,2,4,8
// - external input always synchronised, disable bit kept readable only
// - source bit picks external or instruction clock
// - run bit gates counting, holds value
// - timer mode counts each instruction cycle
// - counter mode counts external or aux edges
// - wrap to zero sets overflow flag
// - flag raises irq only when enabled
// - special trigger in mode 1011 clears count
// - trigger reset never sets overflow flag
// - software write beats trigger reset
// - compare value acts as period
// - aux oscillator may serve as clock
// - low read latches high byte buffer
// - high write fills buffer, low write commits
// - only low byte write clears prescaler
module mctr_top (
    input wire logic i_clk,
    input wire logic i_reset,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // external count input and aux oscillator, both async
    input wire logic i_ext_count_input,
    input wire logic i_aux_osc,
    input wire logic i_aux_osc_enable,
    // capture/compare unit interface
    input wire logic [3:0] i_compare_mode_field,
    input wire logic i_compare_match,
    input wire logic [15:0] i_companion_count,
    output logic [15:0] o_count,
    output logic [15:0] o_ch1_timebase,
    output logic [15:0] o_ch2_timebase,
    output logic o_overflow_flag,
    output logic o_irq
);
    import mctr_pkg::*;

    logic [7:0] ctrl_reg; // control register
    logic [15:0] count_reg; // live count
    logic [7:0] hbuf_reg; // high byte buffer for wide access
    logic flag_reg; // overflow flag
    logic irq_en_reg; // overflow interrupt enable
    logic [1:0] instr_reg; // instruction cycle divider
    logic ext_a_reg; // first sync stage
    logic ext_b_reg; // second sync stage
    logic [31:0] prdata_reg; // read data register
    logic ext_src; // chosen external raw level
    logic ext_level; // level fed to the edge detector
    logic ext_rise; // rising edge pulse
    logic instr_tick; // one pulse per instruction cycle
    logic raw_tick; // pre-prescaler tick
    logic count_tick; // post-prescaler tick
    logic wr_acc; // write access phase
    logic rd_acc; // read setup phase, where reads are decoded
    logic wr_low; // low byte write
    logic wr_high; // high byte write
    logic trig_clear; // special event reset
    logic wrap; // overflow this cycle
    logic wide; // atomic mode

    // apb answers in the first access cycle, never an error
    assign o_pready = 1'b1;
    assign o_pslverr = 1'b0;
    assign wr_acc = i_psel && i_penable && i_pwrite;
    assign rd_acc = i_psel && !i_penable && !i_pwrite;
    assign wr_low = wr_acc && (i_paddr == MCTR_ADDR_CNTL);
    assign wr_high = wr_acc && (i_paddr == MCTR_ADDR_CNTH);
    assign wide = ctrl_reg[MCTR_CTRL_WIDE];

    // control register; only the software writes it
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_reg <= MCTR_CTRL_RST;
        end else if (wr_acc && (i_paddr == MCTR_ADDR_CTRL)) begin
            ctrl_reg <= i_pwdata[7:0];
        end
    end

    // aux oscillator replaces the pin when enabled
    assign ext_src = i_aux_osc_enable ? i_aux_osc : i_ext_count_input;

    // two stage synchroniser on the chosen external clock
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ext_a_reg <= 1'b0;
            ext_b_reg <= 1'b0;
        end else begin
            ext_a_reg <= ext_src;
            ext_b_reg <= ext_a_reg;
        end
    end

    // the unsynchronised path still goes through the two flops, since
    // this core has one clock; the disable bit is kept readable only
    assign ext_level = ext_b_reg;

    mctr_edge u_edge (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_level(ext_level),
        .i_clear(!ctrl_reg[MCTR_CTRL_SRC]),
        .o_rise(ext_rise)
    );

    // instruction cycle is every fourth system clock
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            instr_reg <= 2'h0;
        end else begin
            instr_reg <= instr_reg + 2'h1;
        end
    end
    assign instr_tick = (instr_reg == MCTR_INSTR_DIV);

    // source select, then the run gate
    assign raw_tick = ctrl_reg[MCTR_CTRL_RUN]
        && (ctrl_reg[MCTR_CTRL_SRC] ? ext_rise : instr_tick);

    mctr_prescale u_prescale (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_tick(raw_tick),
        .i_clear(wr_low),
        .i_sel(ctrl_reg[MCTR_CTRL_PS_HI:MCTR_CTRL_PS_LO]),
        .o_tick(count_tick)
    );

    // trigger from the compare unit in special event mode
    assign trig_clear = i_compare_match
        && (i_compare_mode_field == MCTR_MODE_SPECIAL);
    // a wide high write only fills the buffer, so it must not hide a wrap
    assign wrap = count_tick && !trig_clear && !wr_low
        && !(wr_high && !wide) && (count_reg == 16'hFFFF);

    // live count: write, then trigger, then tick
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            count_reg <= MCTR_COUNT_RST;
        end else if (wr_low) begin
            if (wide) begin
                count_reg <= {hbuf_reg, i_pwdata[7:0]};
            end else begin
                count_reg[7:0] <= i_pwdata[7:0];
            end
        end else if (wr_high && !wide) begin
            count_reg[15:8] <= i_pwdata[7:0];
        end else if (trig_clear) begin
            count_reg <= MCTR_COUNT_RST;
        end else if (count_tick) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // high byte buffer for atomic access; latched in the same setup
    // cycle that samples the low byte, so both halves share one count
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            hbuf_reg <= 8'h00;
        end else if (wide && wr_high) begin
            hbuf_reg <= i_pwdata[7:0];
        end else if (wide && rd_acc && i_paddr == MCTR_ADDR_CNTL) begin
            hbuf_reg <= count_reg[15:8];
        end
    end

    // overflow flag: set wins over a software clear
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            flag_reg <= 1'b0;
            irq_en_reg <= 1'b0;
        end else begin
            if (wrap) begin
                flag_reg <= 1'b1;
            end else if (wr_acc && i_paddr == MCTR_ADDR_IRQ) begin
                flag_reg <= i_pwdata[MCTR_IRQ_FLAG];
            end
            if (wr_acc && i_paddr == MCTR_ADDR_IRQ) begin
                irq_en_reg <= i_pwdata[MCTR_IRQ_EN];
            end
        end
    end

    assign o_overflow_flag = flag_reg;
    assign o_irq = flag_reg && irq_en_reg;
    assign o_count = count_reg;

    // time base routing to the capture/compare channels
    always_comb begin
        if (ctrl_reg[MCTR_CTRL_ROUTE_HI]) begin
            o_ch1_timebase = count_reg;
            o_ch2_timebase = count_reg;
        end else if (ctrl_reg[MCTR_CTRL_ROUTE_LO]) begin
            o_ch1_timebase = i_companion_count;
            o_ch2_timebase = count_reg;
        end else begin
            o_ch1_timebase = i_companion_count;
            o_ch2_timebase = i_companion_count;
        end
    end

    // read data is registered during the setup cycle
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_acc) begin
            case (i_paddr)
                MCTR_ADDR_CTRL: prdata_reg <= {24'h00_0000, ctrl_reg};
                MCTR_ADDR_CNTL: prdata_reg <= {24'h00_0000, count_reg[7:0]};
                MCTR_ADDR_CNTH: prdata_reg <= {24'h00_0000,
                    wide ? hbuf_reg : count_reg[15:8]};
                MCTR_ADDR_IRQ: prdata_reg <= {22'h00_0000, irq_en_reg,
                    7'h00, flag_reg, 1'b0};
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end
    end
    assign o_prdata = prdata_reg;

    // trigger reset must not raise the flag
    a_trig_no_flag: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (trig_clear && !wr_low && !wr_high && !flag_reg
         && !(wr_acc && i_paddr == MCTR_ADDR_IRQ))
        |=> !flag_reg)
        else $error("trigger reset set the overflow flag");

    a_trig_clears: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (trig_clear && !wr_low && !wr_high) |=> (count_reg == 16'h0000))
        else $error("trigger did not clear the count");

    a_write_wins: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (wr_low && trig_clear && !wide)
        |=> (count_reg[7:0] == $past(i_pwdata[7:0])))
        else $error("write lost to trigger reset");

    a_run_holds: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (!ctrl_reg[MCTR_CTRL_RUN] && !wr_acc && !trig_clear)
        |=> $stable(count_reg))
        else $error("count moved while stopped");

    // no tick can leave the prescaler while the run bit is clear
    a_stop_no_tick: assert property (
        @(posedge i_clk) disable iff (i_reset)
        !ctrl_reg[MCTR_CTRL_RUN] |-> !count_tick)
        else $error("tick while stopped");

    a_wrap_flag: assert property (
        @(posedge i_clk) disable iff (i_reset)
        wrap |=> (flag_reg && count_reg == 16'h0000))
        else $error("wrap did not set the flag");

    // a plain tick moves the count by exactly one
    a_tick_step: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (count_tick && !wr_low && !wr_high && !trig_clear)
        |=> (count_reg == $past(count_reg) + 16'h0001))
        else $error("tick did not add one");

    // only a software write to the irq register drops the flag
    a_flag_sticky: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (flag_reg && !(wr_acc && i_paddr == MCTR_ADDR_IRQ)) |=> flag_reg)
        else $error("overflow flag dropped on its own");

    // the line follows the written flag and enable together
    a_irq_gate: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (wr_acc && i_paddr == MCTR_ADDR_IRQ && !wrap)
        |=> (o_irq == ($past(i_pwdata[MCTR_IRQ_FLAG])
            && $past(i_pwdata[MCTR_IRQ_EN]))))
        else $error("irq not gated by enable");

    // byte mode: a low write leaves the live high byte alone
    a_byte_low: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (wr_low && !wide) |=> (count_reg
            == {$past(count_reg[15:8]), $past(i_pwdata[7:0])}))
        else $error("byte low write touched the high byte");

    // byte mode: a high write goes straight to the live count
    a_byte_high: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (wr_high && !wide) |=> (count_reg
            == {$past(i_pwdata[7:0]), $past(count_reg[7:0])}))
        else $error("byte high write missed the count");

    // wide mode: the low write commits buffer and low byte at once
    a_wide_commit: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (wr_low && wide) |=> (count_reg
            == {$past(hbuf_reg), $past(i_pwdata[7:0])}))
        else $error("wide write did not commit 16 bits");

    sequence s_hi_write;
        wide && wr_high;
    endsequence
    a_hi_buffered: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (s_hi_write and !wr_low and !trig_clear and !count_tick)
        |=> $stable(count_reg))
        else $error("high write reached live count");

    a_low_read_latch: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (wide && rd_acc && i_paddr == MCTR_ADDR_CNTL && !wr_high)
        |=> (hbuf_reg == $past(count_reg[15:8])))
        else $error("low read did not latch high byte");

    a_timer_rate: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (raw_tick && !ctrl_reg[MCTR_CTRL_SRC]) |=> !raw_tick [*3])
        else $error("timer ticked faster than instruction rate");

    a_route_full: assert property (
        @(posedge i_clk) disable iff (i_reset)
        ctrl_reg[MCTR_CTRL_ROUTE_HI] |-> (o_ch1_timebase == count_reg))
        else $error("route code 1x wrong");

    // split route: companion timer on channel 1, this count on channel 2
    a_route_split: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (!ctrl_reg[MCTR_CTRL_ROUTE_HI] && ctrl_reg[MCTR_CTRL_ROUTE_LO])
        |-> (o_ch1_timebase == i_companion_count
            && o_ch2_timebase == count_reg))
        else $error("route code 01 wrong");

    a_route_none: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (!ctrl_reg[MCTR_CTRL_ROUTE_HI] && !ctrl_reg[MCTR_CTRL_ROUTE_LO])
        |-> (o_ch1_timebase == i_companion_count
            && o_ch2_timebase == i_companion_count))
        else $error("route code 00 wrong");

    // an external rise is only counted after a low has been seen
    a_rise_after_low: assert property (
        @(posedge i_clk) disable iff (i_reset)
        ext_rise |-> (ctrl_reg[MCTR_CTRL_SRC] && $past(ext_level) == 1'b0))
        else $error("external rise counted without a low first");
endmodule

/* File: testbench/mctr_top_test.sv */
`timescale 1ns/1ps
// self-checking bench for the 16-bit timer/counter, driven over apb
module mctr_top_test;
    import mctr_pkg::*;

    logic i_clk = 1'b0; // 200 mhz system clock
    logic i_reset = 1'b1; // async, held at start
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic i_ext_count_input = 1'b1; // idles high, so a fall comes first
    logic i_aux_osc = 1'b1;
    logic i_aux_osc_enable = 1'b0;
    logic [3:0] i_compare_mode_field = 4'h0;
    logic i_compare_match = 1'b0;
    logic [15:0] i_companion_count = 16'h1234; // fixed companion value
    logic [15:0] o_count;
    logic [15:0] o_ch1_timebase;
    logic [15:0] o_ch2_timebase;
    logic o_overflow_flag;
    logic o_irq;
    logic trig = 1'b0; // fire a match alongside the next apb access
    logic [31:0] rd; // last read data
    logic [15:0] hold; // snapshot of the count
    logic err; // slave error seen with the last answer
    int n_mismatch = 0;
    int total_checks = 0;
    int p; // measured tick period in clocks

    mctr_top dut (.i_clk, .i_reset, .i_psel, .i_penable, .i_pwrite,
        .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
        .i_ext_count_input, .i_aux_osc, .i_aux_osc_enable,
        .i_compare_mode_field, .i_compare_match, .i_companion_count,
        .o_count, .o_ch1_timebase, .o_ch2_timebase, .o_overflow_flag,
        .o_irq);

    // free-running clock, 5 ns period
    always #2.5 i_clk = ~i_clk;

    // one compare for every value checked
    task automatic chk(input string what, input logic [15:0] e,
            input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    // one apb transfer; read data taken at the edge that sees pready
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [15:0] d);
        int n;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= {16'h0000, d};
        @(posedge i_clk);
        i_penable <= 1'b1;
        i_compare_match <= trig; // lands on the same edge as the write
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++; // slave never answered
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        i_compare_match <= 1'b0;
        // let the edge pass so that callers see the settled result
        @(posedge i_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rb(input logic [11:0] a);
        apb(1'b0, a, 16'h0000);
    endtask

    // clocks between two count changes, sampled away from the edge
    task automatic per(output int q);
        logic [15:0] c;
        int n;
        @(negedge i_clk);
        c = o_count;
        n = 0;
        while (o_count === c && n < 100) begin
            @(negedge i_clk);
            n++;
        end
        c = o_count;
        q = 0;
        while (o_count === c && q < 100) begin
            @(negedge i_clk);
            q++;
        end
    endtask

    // single exit point for pass, fail and hang
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog, far beyond the roughly 800 cycles the tests need
    initial begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        $display("watchdog expired");
        test_done;
    end

    initial begin
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        rb(MCTR_ADDR_CTRL);
        chk("ctrl reset", 16'h0000, {8'h00, rd[7:0]});
        chk("count reset", 16'h0000, o_count);
        chk("flag reset", 16'h0000, {15'h0000, o_overflow_flag});
        // unmapped place: reads zero, write has no effect
        wr(12'h010, 16'h00FF);
        chk("slave error", 16'h0000, {15'h0000, err});
        rb(12'h010);
        chk("unmapped", 16'h0000, rd[15:0]);
        rb(MCTR_ADDR_CTRL);
        chk("ctrl kept", 16'h0000, {8'h00, rd[7:0]});
        $display("test reset done");

        // byte mode: each byte lands on its own
        wr(MCTR_ADDR_CNTL, 16'h005A);
        chk("low only", 16'h005A, o_count);
        wr(MCTR_ADDR_CNTH, 16'h00A5);
        chk("high only", 16'hA55A, o_count);
        // every route code, count stopped at a known value
        for (int k = 0; k < 4; k++) begin
            wr(MCTR_ADDR_CTRL, {9'h000, k[1], 2'b00, k[0], 3'b000});
            rb(MCTR_ADDR_CTRL);
            chk("ctrl rw", {9'h000, k[1], 2'b00, k[0], 3'b000},
                {8'h00, rd[7:0]});
            chk("ch1", k[1] ? 16'hA55A : 16'h1234, o_ch1_timebase);
            chk("ch2", k != 0 ? 16'hA55A : 16'h1234, o_ch2_timebase);
        end
        $display("test route done");

        // wide mode: high write waits in the buffer for the low write
        wr(MCTR_ADDR_CTRL, 16'h0080);
        wr(MCTR_ADDR_CNTH, 16'h003C);
        chk("high buffered", 16'hA55A, o_count);
        wr(MCTR_ADDR_CNTL, 16'h00C3);
        chk("wide commit", 16'h3CC3, o_count);
        wr(MCTR_ADDR_CTRL, 16'h0000);
        wr(MCTR_ADDR_CNTH, 16'h0077);
        wr(MCTR_ADDR_CTRL, 16'h0080);
        rb(MCTR_ADDR_CNTL);
        chk("wide low read", 16'h00C3, {8'h00, rd[7:0]});
        rb(MCTR_ADDR_CNTH);
        chk("wide high read", 16'h0077, {8'h00, rd[7:0]});
        // live high moves to 55, the buffer must still answer 77
        wr(MCTR_ADDR_CTRL, 16'h0000);
        wr(MCTR_ADDR_CNTH, 16'h0055);
        wr(MCTR_ADDR_CTRL, 16'h0080);
        rb(MCTR_ADDR_CNTH);
        chk("buffer not live", 16'h0077, {8'h00, rd[7:0]});
        $display("test wide done");

        // internal clock: four system clocks per tick times prescale
        for (int s = 0; s < 4; s++) begin
            wr(MCTR_ADDR_CTRL, {10'h000, s[1:0], 4'h1});
            per(p);
            per(p); // second period, clear of the switch-over
            chk("tick period", 16'(4 << s), 16'(p));
        end
        wr(MCTR_ADDR_CTRL, 16'h0000);
        hold = o_count;
        repeat (40) @(posedge i_clk);
        chk("stopped", hold, o_count);
        $display("test prescale done");

        // wrap to zero latches the flag; irq follows the enable
        wr(MCTR_ADDR_CNTH, 16'h00FF);
        wr(MCTR_ADDR_CNTL, 16'h00FD);
        wr(MCTR_ADDR_CTRL, 16'h0001);
        for (int n = 0; n < 100 && o_count !== 16'h0000; n++)
            @(negedge i_clk);
        chk("wrapped", 16'h0000, o_count);
        chk("flag set", 16'h0001, {15'h0000, o_overflow_flag});
        chk("irq masked", 16'h0000, {15'h0000, o_irq});
        wr(MCTR_ADDR_IRQ, 16'h0202);
        chk("irq on", 16'h0001, {15'h0000, o_irq});
        rb(MCTR_ADDR_IRQ);
        chk("irq reg", 16'h0202, rd[15:0] & 16'h0202);
        wr(MCTR_ADDR_CTRL, 16'h0000);
        wr(MCTR_ADDR_IRQ, 16'h0200);
        chk("flag clear", 16'h0000, {15'h0000, o_overflow_flag});
        chk("irq off", 16'h0000, {15'h0000, o_irq});
        $display("test overflow done");

        // special event trigger, only in its own compare mode
        // kept in timer mode: async counter mode does not promise it
        wr(MCTR_ADDR_CTRL, 16'h0000);
        wr(MCTR_ADDR_CNTH, 16'h0012);
        wr(MCTR_ADDR_CNTL, 16'h0040);
        for (int m = 10; m < 12; m++) begin
            i_compare_mode_field <= 4'(m);
            @(posedge i_clk);
            i_compare_match <= 1'b1;
            @(posedge i_clk);
            i_compare_match <= 1'b0;
            repeat (2) @(posedge i_clk);
            chk("trigger", m == 11 ? 16'h0000 : 16'h1240, o_count);
        end
        chk("no flag", 16'h0000, {15'h0000, o_overflow_flag});
        wr(MCTR_ADDR_CNTH, 16'h0012);
        trig = 1'b1;
        wr(MCTR_ADDR_CNTL, 16'h0066);
        trig = 1'b0;
        repeat (2) @(posedge i_clk);
        chk("write wins", 16'h1266, o_count);
        $display("test trigger done");

        // external source: pin, pin with the sync disable bit set, aux oscillator
        for (int c = 0; c < 3; c++) begin
            wr(MCTR_ADDR_CTRL, 16'h0000);
            wr(MCTR_ADDR_CNTH, 16'h0000);
            wr(MCTR_ADDR_CNTL, 16'h0000);
            i_aux_osc_enable <= (c == 2);
            wr(MCTR_ADDR_CTRL, c == 1 ? 16'h0007 : 16'h0003);
            repeat (5) begin
                for (int lv = 0; lv < 2; lv++) begin
                    @(posedge i_clk);
                    if (c == 2)
                        i_aux_osc <= lv[0];
                    else
                        i_ext_count_input <= lv[0];
                    repeat (6) @(posedge i_clk);
                end
            end
            repeat (10) @(posedge i_clk);
            chk("edge count", 16'h0005, o_count);
        end
        $display("test external done");
        test_done;
    end
endmodule
